/* File: rtl/alc_cfg.svh */
/*
  Constants for the microphone automatic level control block: register
  offsets, reset values, gain code landmarks and timing base counts.
  Assumes an APB slave with byte addresses and a strobe at twice fs.
*/
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH

// ==========================================================
// Register map
`define ADDR_W          12
`define ADDR_CTRL       12'h000
`define ADDR_GAIN       12'h004
`define ADDR_REF        12'h008
`define ADDR_STATUS     12'h00c
`define CTRL_W          16

// ==========================================================
// Reset values
`define CTRL_RESET      16'h0000
`define GAIN_RESET      6'h08
`define REF_RESET       6'h2d

// ==========================================================
// Gain code landmarks
`define GAIN_ZERO_DB    6'h08
`define GAIN_MAX        6'h3f
`define GAIN_MIN        6'h00
`define GAIN_ONE_CODE   6'h01
`define GAIN_TWO_CODES  6'h02
`define REF_MAX         6'h3d
`define REF_LOW_TOP     6'h01
`define REF_OFFSET      6'h04

// ==========================================================
// Timing in strobe ticks at twice fs
`define ZC_TIMEOUT_BASE 12'h100
`define LIMIT_PER_BASE  12'h001
`define WAIT_BASE       12'h100

`endif

/* File: rtl/alc_pkg.sv */
/*
  Types shared by the automatic level control block: loop states,
  control field layout, level comparator flags and status layout.
  Assumes the constants header is included by the design files.
*/
package alc_pkg;

  // ==========================================================
  // Loop states
  typedef enum logic [3:0] {
    ST_MANUAL  = 4'b0001,
    ST_LIMIT   = 4'b0010,
    ST_WAIT    = 4'b0100,
    ST_RECOVER = 4'b1000
  } alc_state_t;

  // ==========================================================
  // Control register fields, msb first
  typedef struct packed {
    logic [1:0] recovery_wait_select;
    logic [1:0] zero_cross_timeout_select;
    logic [1:0] limit_period_select;
    logic [1:0] limit_atten_step;
    logic       recovery_step_select;
    logic       zero_cross_limit_disable;
    logic       limit_threshold_select;
    logic       detect_pin_to_right_line;
    logic       ext_mic_power_enable;
    logic       mic_path_power;
    logic       mic_mute;
    logic       auto_level_enable;
  } ctrl_t;

  // ==========================================================
  // Level comparators on the gain stage output
  typedef struct packed {
    logic ge_m4;
    logic ge_m6;
    logic ge_m8;
  } level_flags_t;

  // ==========================================================
  // Status register layout
  typedef struct packed {
    logic [9:0] pad_hi;
    logic [5:0] gain;
    logic [3:0] pad_mid;
    alc_state_t state;
    logic [6:0] pad_lo;
    logic       ext_mic_present;
  } status_t;

endpackage

/* File: rtl/alc_tick_timer.sv */
/*
  Period timer counting strobe ticks up to a programmable limit.
  Assumes tick is a one-cycle enable and restart is synchronous.
*/
`timescale 1ns/1ns
module alc_tick_timer #(
  parameter int W = 12
) (
  input  wire logic         pclk,    // System clock
  input  wire logic         presetn, // Async reset, active low
  input  wire logic         tick,    // Rate strobe
  input  wire logic         restart, // Clear count
  input  wire logic [W-1:0] limit,   // Ticks per period
  output logic              done     // Pulse at period end
);

  logic [W-1:0] count_ff;
  logic         done_ff;
  logic [W-1:0] nxt_count;
  logic         nxt_done;
  wire  [W-1:0] count_inc;
  wire          hit;

  assign count_inc = count_ff + {{(W-1){1'b0}}, 1'b1};
  assign hit       = tick && (count_inc >= limit);
  // Auto reload so a stalled loop still sees regular periods
  assign nxt_count = (restart || hit) ? '0 :
                     tick ? count_inc : count_ff;
  assign nxt_done  = !restart && hit;
  assign done      = done_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff  <= nxt_done;
    end
  end

endmodule

/* File: rtl/mic_auto_level_control.sv */
/*
  Microphone input gain control: manual gain, limiter, recovery loop,
  zero-cross timed gain updates, external mic detection, APB registers.
  Assumes all inputs are synchronous to pclk, a strobe at twice fs,
  and analog comparators that report the gain stage output level.
*/
`timescale 1ns/1ns
`include "alc_cfg.svh"
module mic_auto_level_control #(
  parameter int TICK_W = 12
) (
  input  wire logic                 pclk,          // 125 MHz clock
  input  wire logic                 presetn,       // Async reset, low
  input  wire logic                 psel,          // APB select
  input  wire logic                 penable,       // APB enable
  input  wire logic                 pwrite,        // APB write
  input  wire logic [`ADDR_W-1:0]   paddr,         // APB byte address
  input  wire logic [31:0]          pwdata,        // APB write data
  output logic      [31:0]          prdata,        // APB read data
  output logic                      pready,        // APB ready
  output logic                      pslverr,       // APB error
  input  wire logic                 fs2_tick,      // Strobe at 2x fs
  input  wire logic                 zero_cross,    // Waveform crossing
  input  wire alc_pkg::level_flags_t level,        // Output level flags
  input  wire logic                 det_above_hi,  // Detect pin high
  input  wire logic                 det_below_lo,  // Detect pin low
  output logic      [5:0]           gain_code,     // Gain stage code
  output logic                      gain_mute,     // Gain stage mute
  output logic                      ext_mic_power_pin, // Mic supply on
  output logic                      right_line_input,  // Pin reuse
  output logic                      ext_mic_present    // Detect flag
);
  import alc_pkg::*;

  // ==========================================================
  // Registers
  ctrl_t        ctrl_ff;
  logic [5:0]   manual_gain_ff;
  logic [5:0]   ref_ff;
  logic [5:0]   gain_ff;
  alc_state_t   state_ff;
  logic         manual_pend_ff;
  logic         present_ff;
  logic         mute_ff;
  logic         mic_pwr_ff;
  logic         rline_ff;
  logic         pready_ff;
  logic         pslverr_ff;
  logic [31:0]  prdata_ff;

  logic [5:0]   nxt_gain;
  alc_state_t   nxt_state;
  logic         nxt_manual_pend;
  logic         nxt_present;
  logic [31:0]  nxt_prdata;
  logic         nxt_pready;
  logic         nxt_pslverr;

  // ==========================================================
  // APB decode
  wire apb_access = psel && penable;
  wire apb_first  = apb_access && !pready_ff;
  wire apb_done   = apb_access && pready_ff;
  wire hit_ctrl   = (paddr == `ADDR_CTRL);
  wire hit_gain   = (paddr == `ADDR_GAIN);
  wire hit_ref    = (paddr == `ADDR_REF);
  wire hit_status = (paddr == `ADDR_STATUS);
  wire addr_hit   = hit_ctrl || hit_gain || hit_ref || hit_status;
  wire wr_ctrl    = apb_done && pwrite && hit_ctrl;
  wire wr_gain    = apb_done && pwrite && hit_gain;
  wire wr_ref     = apb_done && pwrite && hit_ref;

  status_t status_word;
  assign status_word = '{pad_hi: '0, gain: gain_ff, pad_mid: '0,
                         state: state_ff, pad_lo: '0,
                         ext_mic_present: present_ff};

  wire [31:0] rd_mux = hit_ctrl   ? 32'(ctrl_ff) :
                       hit_gain   ? 32'(gain_ff) :
                       hit_ref    ? 32'(ref_ff) :
                       hit_status ? 32'(status_word) : 32'h0000_0000;

  // One wait state: the answer is ready on the second access cycle
  assign nxt_pready  = apb_first;
  assign nxt_pslverr = apb_first && !addr_hit;
  assign nxt_prdata  = (apb_first && !pwrite) ? rd_mux : prdata_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Loop settings are taken as written; changing them mid-loop is
  // left to software, the loop does not freeze them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ctrl_t'(`CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_ff <= ctrl_t'(pwdata[`CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_gain_ff <= `GAIN_RESET;
    end else if (wr_gain) begin
      manual_gain_ff <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ff <= `REF_RESET;
    end else if (wr_ref) begin
      ref_ff <= pwdata[5:0];
    end
  end

  // ==========================================================
  // Level decisions
  wire loop_on  = ctrl_ff.auto_level_enable && ctrl_ff.mic_path_power;
  wire ge_limit = ctrl_ff.limit_threshold_select ? level.ge_m4 :
                                                   level.ge_m6;
  wire ge_reset = ctrl_ff.limit_threshold_select ? level.ge_m6 :
                                                   level.ge_m8;
  wire in_band  = ge_reset && !ge_limit;

  // ==========================================================
  // Reference code to gain code
  // Reference is offset by four codes above 0 dB; its two lowest codes
  // coincide with the gain table's
  wire [6:0] ref_sum  = {1'b0, ref_ff} + 7'(`REF_OFFSET);
  // Top reference codes would run past the gain table's end, so clamp
  wire [5:0] ref_gain = ((ref_ff > `REF_MAX) ||
                         (ref_sum > 7'(`GAIN_MAX))) ? `GAIN_MAX :
                        (ref_ff > `REF_LOW_TOP) ? ref_sum[5:0] :
                                                  ref_ff;

  // ==========================================================
  // Limiter step
  wire       gain_above = gain_ff > `GAIN_ZERO_DB;
  wire [5:0] att_step   = {4'h0, ctrl_ff.limit_atten_step} +
                          `GAIN_ONE_CODE;
  wire [5:0] room_dn    = gain_ff - `GAIN_ZERO_DB;
  // Large steps stop at 0 dB so the half dB scale is not overshot
  wire [5:0] gain_big   = (room_dn < att_step) ? `GAIN_ZERO_DB :
                                                 gain_ff - att_step;
  wire [5:0] gain_small = (gain_ff == `GAIN_MIN) ? `GAIN_MIN :
                          gain_ff - `GAIN_ONE_CODE;
  wire [5:0] gain_dn    = gain_above ? gain_big : gain_small;

  // ==========================================================
  // Recovery step
  // Below 0 dB one code is already 1 dB, so the fine step is one code
  wire [5:0] rec_step  = (gain_above && ctrl_ff.recovery_step_select) ?
                         `GAIN_TWO_CODES : `GAIN_ONE_CODE;
  wire [6:0] gain_upw  = {1'b0, gain_ff} + {1'b0, rec_step};
  wire [5:0] gain_up   = (gain_upw >= {1'b0, ref_gain}) ? ref_gain :
                         gain_upw[5:0];
  wire       at_ref    = gain_ff >= ref_gain;

  // ==========================================================
  // Gain update timing
  wire st_manual  = (state_ff == ST_MANUAL);
  wire st_limit   = (state_ff == ST_LIMIT);
  wire st_wait    = (state_ff == ST_WAIT);
  wire st_recover = (state_ff == ST_RECOVER);

  wire pending = st_manual  ? manual_pend_ff :
                 st_limit   ? ge_limit :
                 st_recover ? (!at_ref && !ge_reset) : 1'b0;

  wire use_period = st_limit && ctrl_ff.zero_cross_limit_disable;
  wire [TICK_W-1:0] zc_limit  = TICK_W'(`ZC_TIMEOUT_BASE <<
                                ctrl_ff.zero_cross_timeout_select);
  wire [TICK_W-1:0] per_limit = TICK_W'(`LIMIT_PER_BASE <<
                                ctrl_ff.limit_period_select);
  wire [TICK_W-1:0] wt_limit  = TICK_W'(`WAIT_BASE <<
                                ctrl_ff.recovery_wait_select);
  wire [TICK_W-1:0] step_limit = use_period ? per_limit :
                                              zc_limit;
  wire step_done;
  wire wait_done;
  // Crossings are ignored in fixed period mode
  wire apply_evt  = use_period ? step_done :
                                 (zero_cross || step_done);
  wire gain_apply = pending && apply_evt;
  wire step_restart = !pending || gain_apply;
  // Timer restarts on entry to the wait and inside the reset band
  wire wait_restart = !st_wait || ge_reset;

  alc_tick_timer #(
    .W       (TICK_W)
  ) u_step_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (fs2_tick),
    .restart (step_restart),
    .limit   (step_limit),
    .done    (step_done)
  );

  alc_tick_timer #(
    .W       (TICK_W)
  ) u_wait_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (fs2_tick),
    .restart (wait_restart),
    .limit   (wt_limit),
    .done    (wait_done)
  );

  // ==========================================================
  // Loop state machine
  always_comb begin
    nxt_state = state_ff;
    if (!loop_on) begin
      nxt_state = ST_MANUAL;
    end else begin
      unique case (state_ff)
        ST_MANUAL: begin
          nxt_state = ge_limit ? ST_LIMIT : ST_WAIT;
        end
        ST_LIMIT: begin
          if (!ge_limit) begin
            nxt_state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ge_limit) begin
            nxt_state = ST_LIMIT;
          end else if (wait_done) begin
            nxt_state = ST_RECOVER;
          end
        end
        ST_RECOVER: begin
          if (ge_limit) begin
            nxt_state = ST_LIMIT;
          end else if (in_band || gain_apply || at_ref) begin
            nxt_state = ST_WAIT;
          end
        end
        default: begin
          nxt_state = ST_MANUAL;
        end
      endcase
    end
  end

  // ==========================================================
  // Gain value
  // Leaving the loop keeps gain_ff; only a later write changes it
  always_comb begin
    nxt_gain = gain_ff;
    if (gain_apply) begin
      if (st_manual) begin
        nxt_gain = manual_gain_ff;
      end else if (st_limit) begin
        nxt_gain = gain_dn;
      end else if (st_recover) begin
        nxt_gain = gain_up;
      end
    end
  end

  // A write in the same cycle as an apply keeps the request alive
  assign nxt_manual_pend = !st_manual ? 1'b0 :
                           wr_gain    ? 1'b1 :
                           gain_apply ? 1'b0 : manual_pend_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff       <= ST_MANUAL;
      gain_ff        <= `GAIN_RESET;
      manual_pend_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;
      gain_ff        <= nxt_gain;
      manual_pend_ff <= nxt_manual_pend;
    end
  end

  // ==========================================================
  // External microphone detection
  // Hysteresis: between the two thresholds the flag holds
  assign nxt_present = ctrl_ff.detect_pin_to_right_line ? 1'b0 :
                       det_above_hi ? 1'b1 :
                       det_below_lo ? 1'b0 : present_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_ff <= 1'b0;
      mute_ff    <= 1'b0;
      mic_pwr_ff <= 1'b0;
      rline_ff   <= 1'b0;
    end else begin
      present_ff <= nxt_present;
      mute_ff    <= ctrl_ff.mic_mute;
      mic_pwr_ff <= ctrl_ff.mic_path_power &&
                    ctrl_ff.ext_mic_power_enable;
      rline_ff   <= ctrl_ff.detect_pin_to_right_line;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign gain_code         = gain_ff;
  assign gain_mute         = mute_ff;
  assign ext_mic_power_pin = mic_pwr_ff;
  assign right_line_input  = rline_ff;
  assign ext_mic_present   = present_ff;

endmodule

/* File: tb/mic_auto_level_control_properties.sv */
/* Port checker for the mic level control block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
module alc_checker (
  input wire logic       pclk,             // Clock
  input wire logic       presetn,          // Reset, low
  input wire logic       psel,             // APB select
  input wire logic       penable,          // APB enable
  input wire logic       pready,           // APB ready
  input wire logic       pslverr,          // APB error
  input wire logic       fs2_tick,         // Rate strobe
  input wire logic       zero_cross,       // Crossing pulse
  input wire logic       det_above_hi,     // Detect high
  input wire logic       det_below_lo,     // Detect low
  input wire logic [5:0] gain_code,        // Gain code
  input wire logic       right_line_input, // Pin reuse
  input wire logic       ext_mic_present   // Detect flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========
  // Detection flag
  AST_DET_SET: assert property (
    (det_above_hi && !right_line_input) [*3] |=>
      ext_mic_present || right_line_input) else $error("flag not set");
  AST_DET_CLR: assert property (
    det_below_lo [*3] |=> !ext_mic_present) else $error("flag not clear");
  AST_DET_RISE: assert property (
    $rose(ext_mic_present) |-> $past(det_above_hi))
    else $error("flag rose without high level");
  AST_DET_FALL: assert property (
    $fell(ext_mic_present) |-> $past(det_below_lo) || right_line_input)
    else $error("flag fell without low level");
  AST_PIN_REUSE: assert property (
    right_line_input |-> !ext_mic_present) else $error("flag while reused");

  // ==========
  // Gain timing and register bus
  AST_GAIN_TIMED: assert property (
    $changed(gain_code) |-> $past(zero_cross) || $past(fs2_tick) ||
      $past(fs2_tick, 2) || $past(fs2_tick, 3))
    else $error("gain moved off strobe");
  AST_READY_TIME: assert property (
    psel && !penable |=> !pready ##1 pready) else $error("ready late");
  AST_READY_PULSE: assert property (
    pready |=> !pready) else $error("ready held");
  AST_ERR_READY: assert property (
    pslverr |-> pready) else $error("error without ready");

  cover property (pslverr);
  cover property ($changed(gain_code));
  cover property ($rose(ext_mic_present));
endmodule

/* File: tb/alc_signal_path.sv */
/* Gain stage and level detector model with rate strobe and crossings.
   Assumes amp is the input level in half dB, 0 meaning 0 dBFS at 0 dB. */
`timescale 1ns/1ns
module alc_signal_path #(
  parameter int TICK_DIV = 4,
  parameter int ZC_DIV   = 37
) (
  input  wire logic              pclk,       // Clock
  input  wire logic              presetn,    // Reset, low
  input  wire logic [5:0]        gain_code,  // Gain code
  input  wire logic              gain_mute,  // Mute
  input  wire logic signed [7:0] amp,        // Input level, half dB
  input  wire logic              zc_en,      // Crossings allowed
  output logic                   fs2_tick,   // Strobe at 2x fs
  output logic                   zero_cross, // Crossing pulse
  output alc_pkg::level_flags_t  level       // Output level flags
);
  import alc_pkg::*;
  int tcnt;
  int zcnt;
  int out_hd;

  // ==========
  // Level, half dB: 0.5 dB codes above 0 dB, 1 dB below
  assign out_hd = int'(amp) + ((gain_code >= 6'h08) ? int'(gain_code) - 8
                               : 2 * (int'(gain_code) - 8));
  assign level.ge_m4 = !gain_mute && out_hd >= -8;
  assign level.ge_m6 = !gain_mute && out_hd >= -12;
  assign level.ge_m8 = !gain_mute && out_hd >= -16;

  // ==========
  // Strobes; crossing period not a multiple of the tick on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 0;
      zcnt <= 0;
      fs2_tick <= 1'b0;
      zero_cross <= 1'b0;
    end else begin
      tcnt <= (tcnt == TICK_DIV - 1) ? 0 : tcnt + 1;
      zcnt <= (zcnt == ZC_DIV - 1) ? 0 : zcnt + 1;
      fs2_tick <= (tcnt == TICK_DIV - 1);
      zero_cross <= zc_en && (zcnt == ZC_DIV - 1);
    end
  end
endmodule

/* File: tb/mic_auto_level_control_tb.sv */
/* Self-checking bench: APB host, signal path model, port checker.
   Assumes package, header and design are compiled first. */
`timescale 1ns/1ns
`include "alc_cfg.svh"
`define CHK(a, x) begin \
  tests_run++; \
  if ((a) !== (x)) begin \
    fails++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, x); \
  end \
end
module mic_auto_level_control_tb;
  import alc_pkg::*;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0;
  logic              det_above_hi = 1'b0;
  logic              det_below_lo = 1'b1;
  logic signed [7:0] amp = -8'sd100;
  logic              zc_en = 1'b1;
  logic [31:0]       prdata, q;
  logic [5:0]        gain_code;
  logic              pready, pslverr, fs2_tick, zero_cross, e;
  logic              gain_mute, ext_mic_power_pin, right_line_input;
  logic              ext_mic_present;
  level_flags_t      level;
  ctrl_t             c;
  int                fails = 0;
  int                tests_run = 0;
  int                g0, a0, r0, ge;

  always #4 pclk = ~pclk;

  mic_auto_level_control u_mic_auto_level_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fs2_tick(fs2_tick),
    .zero_cross(zero_cross), .level(level), .det_above_hi(det_above_hi),
    .det_below_lo(det_below_lo), .gain_code(gain_code),
    .gain_mute(gain_mute), .ext_mic_power_pin(ext_mic_power_pin),
    .right_line_input(right_line_input), .ext_mic_present(ext_mic_present));
  alc_signal_path u_alc_signal_path (
    .pclk(pclk), .presetn(presetn), .gain_code(gain_code),
    .gain_mute(gain_mute), .amp(amp), .zc_en(zc_en),
    .fs2_tick(fs2_tick), .zero_cross(zero_cross), .level(level));

  // ==========
  // Bus and helpers; idle edge first so calls never collide
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  task automatic wc();
    apb(1'b1, `ADDR_CTRL, {16'h0, c});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic int ghd(input int g);
    return (g >= 8) ? g - 8 : 2 * (g - 8);
  endfunction
  // Final gain once the output falls under the limit level
  function automatic int lim_end(input int g, input int a, input int lim,
                                 input int st);
    while (a + ghd(g) >= lim && g > 0)
      g = (g <= 8) ? g - 1 : ((g - st < 8) ? 8 : g - st);
    return g;
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    test_done();
  end

  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'h3fb1));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`ADDR_CTRL, 32'h0);
    rd(`ADDR_GAIN, 32'h8);
    rd(`ADDR_REF, 32'h2d);
    rd(`ADDR_STATUS, 32'h0008_0100);
    rd(12'h010, 32'h0);
    `CHK(e, 1'b1)
    det_below_lo <= 1'b0;
    det_above_hi <= 1'b1;
    cyc(4);
    `CHK(ext_mic_present, 1'b1)
    det_above_hi <= 1'b0;
    cyc(4);
    `CHK(ext_mic_present, 1'b1)
    det_below_lo <= 1'b1;
    cyc(4);
    `CHK(ext_mic_present, 1'b0)
    det_below_lo <= 1'b0;
    det_above_hi <= 1'b1;
    c = '0;
    c.detect_pin_to_right_line = 1'b1;
    c.mic_mute = 1'b1;
    c.mic_path_power = 1'b1;
    c.ext_mic_power_enable = 1'b1;
    wc();
    cyc(3);
    `CHK({right_line_input, ext_mic_present, gain_mute}, 3'b101)
    `CHK(ext_mic_power_pin, 1'b1)
    c = '0;
    c.mic_path_power = 1'b1;
    zc_en <= 1'b0;
    r0 = 8;
    // Timeout alone applies the write, default and doubled period
    for (int k = 0; k < 2; k++) begin
      c.zero_cross_timeout_select = 2'(k);
      wc();
      g0 = (k == 0) ? $urandom_range(63, 9) : (r0 ^ 1);
      apb(1'b1, `ADDR_GAIN, 32'(g0));
      cyc(900 + 1024 * k);
      `CHK(gain_code, 6'(r0))
      cyc(300);
      `CHK(gain_code, 6'(g0))
      r0 = g0;
    end
    zc_en <= 1'b1;
    // Settings change only with the loop off, wait equal to timeout
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.mic_path_power = 1'b1;
      c.limit_atten_step = 2'(i);
      c.limit_period_select = 2'(i);
      c.zero_cross_limit_disable = (i != 3);
      c.limit_threshold_select = i[0];
      amp <= -8'sd100;
      wc();
      g0 = (i == 1) ? $urandom_range(12, 9) : $urandom_range(63, 40);
      apb(1'b1, `ADDR_GAIN, 32'(g0));
      cyc(1100);
      `CHK(gain_code, 6'(g0))
      a0 = $urandom_range(6, 0) - ghd(g0);
      amp <= 8'(a0);
      c.auto_level_enable = 1'b1;
      wc();
      cyc(600);
      ge = lim_end(g0, a0, i[0] ? -8 : -12, i + 1);
      `CHK(gain_code, 6'(ge))
      c.auto_level_enable = 1'b0;
      wc();
      cyc(40);
      `CHK(gain_code, 6'(ge))
    end
    r0 = $urandom_range(8, 5);
    c = '0;
    c.mic_path_power = 1'b1;
    c.recovery_step_select = 1'($urandom_range(1, 0));
    amp <= -8'sd14;
    apb(1'b1, `ADDR_REF, 32'(r0));
    apb(1'b1, `ADDR_GAIN, 32'h8);
    cyc(100);
    c.auto_level_enable = 1'b1;
    wc();
    cyc(1500);
    `CHK(gain_code, 6'h08)
    amp <= -8'sd30;
    cyc(900);
    `CHK(gain_code, 6'h08)
    cyc(5000);
    `CHK(gain_code, 6'(r0 + 4))
    amp <= 8'sd20;
    cyc(100);
    `CHK(gain_code < 6'(r0 + 4), 1'b1)
    test_done();
  end
endmodule

bind mic_auto_level_control alc_checker u_alc_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .fs2_tick(fs2_tick),
  .zero_cross(zero_cross), .det_above_hi(det_above_hi),
  .det_below_lo(det_below_lo), .gain_code(gain_code),
  .right_line_input(right_line_input), .ext_mic_present(ext_mic_present));
